/* File: sim/rdsd_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

module rdsd_host_model (
    // Device side of the pins.
    input  wire logic dev_data_in,
    input  wire logic dev_data_oe_n_in,
    input  wire logic bit_clk_in,
    input  wire logic bit_clk_oe_n_in,
    // Host side.
    input  wire logic tx_level_in,
    output logic      data_pin_out,
    output logic      rx_bit_out
);
    logic host_q = 1'b0;

    initial rx_bit_out = 1'b0;
    assign data_pin_out = dev_data_oe_n_in ? host_q : dev_data_in;
    // New bits go out after a falling clock, away from the rising-edge window.
    always @(negedge bit_clk_in) if (!bit_clk_oe_n_in) host_q <= tx_level_in;
    always @(posedge bit_clk_in) if (!bit_clk_oe_n_in) rx_bit_out <= data_pin_out;
endmodule

`default_nettype wire

/* File: sim/rdsd_top_props.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rdsd_cfg.svh"

module rdsd_top_props
    import rdsd_pkg::*;
(
    // Clocks and reset.
    input wire logic                    ref_clk_in,
    input wire logic                    rst_n_in,
    input wire logic                    link_clk_in,
    // Mode, configuration and modem input.
    input wire logic [1:0]              chip_mode_in,
    input wire logic                    data_mode_hi_in,
    input wire logic                    data_mode_lo_in,
    input wire logic [`RDSD_CFG_W-1:0]  sync_config_reg_in,
    input wire logic [`RDSD_SYNC_W-1:0] sync_value_in,
    input wire logic                    demod_raw_in,
    // Watched outputs.
    input wire logic                    data_pin_out,
    input wire logic                    data_pin_oe_n_out,
    input wire logic                    irq_line_one_out,
    input wire logic                    irq_line_one_oe_n_out,
    input wire logic                    fifo_clear_out,
    input wire logic                    fifo_enable_out,
    input wire logic                    spi_data_enable_out,
    input wire logic                    packet_handler_enable_out,
    input wire logic                    bit_sync_active_out,
    input wire logic                    sync_irq_out,
    input wire logic [`RDSD_SYNC_W-1:0] tx_sync_value_out,
    input wire logic [1:0]              tx_sync_len_sel_out,
    input wire logic [6:0]              payload_limit_out
);
    // Says whether a move between two chip modes must empty the FIFO.
    function automatic logic clr_f(logic [1:0] o, logic [1:0] n, logic hi, logic lo);
        return (o != n) && (n == RDSD_SLEEP || (n == RDSD_RX && o != RDSD_SLEEP) ||
               (o == RDSD_RX && n == RDSD_TX) || (o == RDSD_STANDBY && n == RDSD_TX && !hi && lo));
    endfunction

    clear_needed_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        clr_f($past(chip_mode_in), chip_mode_in, data_mode_hi_in, data_mode_lo_in) |=> fifo_clear_out)
        else $error("fifo clear missing");
    clear_kept_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !clr_f($past(chip_mode_in), chip_mode_in, data_mode_hi_in, data_mode_lo_in) |=> !fifo_clear_out)
        else $error("fifo cleared unexpectedly");
    mode_enables_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        rst_n_in |=> fifo_enable_out == ($past(data_mode_hi_in) | $past(data_mode_lo_in)) &&
        spi_data_enable_out == ($past(data_mode_hi_in) | $past(data_mode_lo_in)) &&
        packet_handler_enable_out == $past(data_mode_hi_in) &&
        bit_sync_active_out == ($past(data_mode_hi_in) | $past(data_mode_lo_in) |
        !$past(sync_config_reg_in[`RDSD_BSYNC_DIS_BIT])) &&
        payload_limit_out == ($past(data_mode_hi_in) ? `RDSD_PAYLOAD_MAX : `RDSD_PAYLOAD_NONE))
        else $error("data mode enables wrong");
    tx_sync_copy_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        rst_n_in |=> tx_sync_value_out == $past(sync_value_in) &&
        tx_sync_len_sel_out == $past(sync_config_reg_in[`RDSD_SYNC_LEN_HI:`RDSD_SYNC_LEN_LO]))
        else $error("transmit sync copy wrong");
    sync_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        sync_irq_out |=> !sync_irq_out [*8])
        else $error("sync event too long or too close");
    sync_gate_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        sync_irq_out |-> sync_config_reg_in[`RDSD_SYNC_EN_BIT] && chip_mode_in == RDSD_RX && bit_sync_active_out)
        else $error("sync event while detection off");
    bitclk_toggle_a: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        !irq_line_one_oe_n_out && $past(irq_line_one_oe_n_out) == 1'b0 |-> irq_line_one_out != $past(irq_line_one_out))
        else $error("bit clock stalled");
    data_on_fall_a: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        !data_pin_oe_n_out && !irq_line_one_oe_n_out && $past(data_pin_oe_n_out) == 1'b0 &&
        data_pin_out != $past(data_pin_out) |-> $fell(irq_line_one_out))
        else $error("receive data changed off falling clock");
    raw_pass_a: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        !data_pin_oe_n_out && irq_line_one_oe_n_out && $past(data_pin_oe_n_out, 4) == 1'b0 |->
        data_pin_out == $past(demod_raw_in, 3))
        else $error("raw data not passed");
endmodule

bind rdsd_top rdsd_top_props rdsd_top_props_inst (.*);

`default_nettype wire

/* File: sim/rdsd_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rdsd_cfg.svh"

module rdsd_top_tb
    import rdsd_pkg::*;
;
    localparam logic [`RDSD_SYNC_W-1:0] SYNC = 32'hC3A5_1E69;
    // Each step is data mode, chip mode and the expected clear pulse.
    localparam logic [4:0] STEPS [15] = '{5'h0A, 5'h0D, 5'h0A, 5'h0F, 5'h0D, 5'h0F, 5'h0A, 5'h09,
                                         5'h0E, 5'h09, 5'h12, 5'h14, 5'h12, 5'h04, 5'h01};
    // Design ports.
    logic ref_clk_in, rst_n_in, link_clk_in, data_mode_hi_in, data_mode_lo_in, demod_raw_in, data_pin_in;
    logic mod_bit_out, data_pin_out, data_pin_oe_n_out, irq_line_one_out, irq_line_one_oe_n_out;
    logic fifo_clear_out, fifo_enable_out, spi_data_enable_out, packet_handler_enable_out;
    logic bit_sync_active_out, sync_irq_out;
    logic [1:0]                chip_mode_in;
    logic [1:0]                tx_sync_len_sel_out;
    logic [6:0]                payload_limit_out;
    logic [`RDSD_CFG_W-1:0]    sync_config_reg_in;
    logic [`RDSD_SYNC_W-1:0]   sync_value_in;
    logic [`RDSD_SYNC_W-1:0]   tx_sync_value_out;
    // Bench state.
    logic                      tx_lvl;
    logic                      host_rx;
    int                        sync_cnt;
    int                        checks;
    int                        miscompares;

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        link_clk_in = 1'b0;
        #2;
        forever #32 link_clk_in = ~link_clk_in;
    end

    rdsd_top rdsd_top_inst (.*);
    rdsd_host_model rdsd_host_model_inst (
        .dev_data_in      (data_pin_out),
        .dev_data_oe_n_in (data_pin_oe_n_out),
        .bit_clk_in       (irq_line_one_out),
        .bit_clk_oe_n_in  (irq_line_one_oe_n_out),
        .tx_level_in      (tx_lvl),
        .data_pin_out     (data_pin_in),
        .rx_bit_out       (host_rx)
    );

    always @(posedge ref_clk_in) begin
        if (sync_irq_out === 1'b1) sync_cnt <= sync_cnt + 1;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic link_wait(input int n);
        repeat (n) @(posedge link_clk_in);
        #1;
    endtask

    task automatic put_bit(input logic b);
        @(posedge link_clk_in) demod_raw_in <= b;
        @(posedge link_clk_in);
    endtask

    task automatic rx_cfg(input logic [7:0] cfg);
        @(posedge ref_clk_in);
        chip_mode_in <= RDSD_STANDBY;
        sync_config_reg_in <= cfg;
        link_wait(8);
        @(posedge ref_clk_in) chip_mode_in <= RDSD_RX;
        link_wait(6);
    endtask

    task automatic send_sync(input int n, input logic [31:0] err, input int exp);
        logic [31:0] w;
        int          base;
        w = SYNC ^ err;
        @(posedge link_clk_in) base = sync_cnt;
        for (int i = 0; i < 24; i++) put_bit(i[0]);
        for (int i = 31; i > 31 - n; i--) put_bit(w[i]);
        repeat (60) @(posedge ref_clk_in);
        chk("sync_event_count", exp, sync_cnt - base);
    endtask

    initial begin
        rst_n_in = 1'b0;
        chip_mode_in = RDSD_SLEEP;
        {data_mode_hi_in, data_mode_lo_in} = RDSD_DM_BUF;
        sync_config_reg_in = 8'h60;
        sync_value_in = SYNC;
        demod_raw_in = 1'b0;
        tx_lvl = 1'b0;
        checks = 0;
        miscompares = 0;
        repeat (5) @(posedge link_clk_in);
        @(posedge ref_clk_in) rst_n_in <= 1'b1;
        link_wait(4);
        foreach (STEPS[i]) begin
            @(posedge ref_clk_in);
            {data_mode_hi_in, data_mode_lo_in} <= STEPS[i][4:3];
            chip_mode_in <= STEPS[i][2:1];
            @(posedge ref_clk_in) #1;
            chk("fifo_clear", STEPS[i][0], fifo_clear_out);
        end
        for (int d = 0; d < 4; d++) begin
            @(posedge ref_clk_in);
            {data_mode_hi_in, data_mode_lo_in} <= d[1:0];
            sync_value_in <= SYNC ^ d;
            repeat (2) @(posedge ref_clk_in);
            #1;
            chk("fifo_enable", d != 0, fifo_enable_out);
            chk("spi_data_enable", d != 0, spi_data_enable_out);
            chk("packet_handler_enable", d[1], packet_handler_enable_out);
            chk("bit_sync_active", d != 0, bit_sync_active_out);
            chk("payload_limit", d[1] ? `RDSD_PAYLOAD_MAX : `RDSD_PAYLOAD_NONE, payload_limit_out);
            chk("tx_sync_value", SYNC ^ d, tx_sync_value_out);
        end
        chk("tx_sync_len_sel", 2, tx_sync_len_sel_out);
        @(posedge ref_clk_in);
        {data_mode_hi_in, data_mode_lo_in} <= RDSD_DM_BUF;
        sync_value_in <= SYNC;
        rx_cfg(8'h30);
        chk("data_pin_oe_n", 1, data_pin_oe_n_out);
        send_sync(32, 32'h0000_0000, 1);
        rx_cfg(8'h32);
        send_sync(32, 32'h0000_0100, 1);
        send_sync(32, 32'h0001_0100, 0);
        rx_cfg(8'h36);
        send_sync(32, 32'h8001_0100, 1);
        rx_cfg(8'h20);
        send_sync(24, 32'h0000_0000, 1);
        rx_cfg(8'h10);
        send_sync(32, 32'h0000_0000, 0);
        @(posedge ref_clk_in);
        {data_mode_hi_in, data_mode_lo_in} <= RDSD_DM_CONT;
        chip_mode_in <= RDSD_STANDBY;
        @(posedge ref_clk_in) chip_mode_in <= RDSD_TX;
        for (int v = 1; v >= 0; v--) begin
            @(posedge link_clk_in) tx_lvl <= v[0];
            link_wait(16);
            chk("modulator_bit", v, mod_bit_out);
            chk("bit_clock_oe_n", 0, irq_line_one_oe_n_out);
        end
        for (int c = 0; c < 2; c++) begin
            rx_cfg(c ? 8'h50 : 8'h10);
            for (int v = 1; v >= 0; v--) begin
                @(posedge link_clk_in) demod_raw_in <= v[0];
                link_wait(16);
                if (c == 0) chk("host_rx_bit", v, host_rx);
                else chk("data_pin", v, data_pin_out);
                chk("bit_clock_oe_n", c, irq_line_one_oe_n_out);
                chk("data_pin_oe_n", 0, data_pin_oe_n_out);
            end
        end
        stop_test();
    end

    initial begin
        #200000;
        miscompares++;
        stop_test();
    end
endmodule

`default_nettype wire

/* File: src/rdsd_cfg.svh */
`ifndef RDSD_CFG_SVH
`define RDSD_CFG_SVH

// Sync configuration register fields.
`define RDSD_SYNC_EN_BIT     5
`define RDSD_SYNC_LEN_HI     5
`define RDSD_SYNC_LEN_LO     4
`define RDSD_SYNC_TOL_HI     2
`define RDSD_SYNC_TOL_LO     1
`define RDSD_BSYNC_DIS_BIT   6

// Widths and limits.
`define RDSD_CFG_W           8
`define RDSD_SYNC_W          32
`define RDSD_BYTE_BITS       8
`define RDSD_PAYLOAD_MAX     7'h40
`define RDSD_PAYLOAD_NONE    7'h00

// Reset values.
`define RDSD_CFG_RST         8'h00
`define RDSD_SYNC_RST        32'h0000_0000

`endif

/* File: src/rdsd_pkg.sv */
`include "rdsd_cfg.svh"

package rdsd_pkg;

    typedef enum logic [1:0] {
        RDSD_SLEEP   = 2'b00,
        RDSD_STANDBY = 2'b01,
        RDSD_TX      = 2'b10,
        RDSD_RX      = 2'b11
    } rdsd_chip_mode_t;

    typedef enum logic [1:0] {
        RDSD_DM_CONT = 2'b00,
        RDSD_DM_BUF  = 2'b01,
        RDSD_DM_PKT  = 2'b10
    } rdsd_data_mode_t;

    typedef enum logic [1:0] {
        RDSD_LK_IDLE    = 2'b00,
        RDSD_LK_CONT_TX = 2'b01,
        RDSD_LK_RX_RAW  = 2'b10,
        RDSD_LK_RX_SYNC = 2'b11
    } rdsd_link_state_t;

    typedef struct packed {
        rdsd_chip_mode_t               chip;
        logic                          dm_hi;
        logic                          dm_lo;
        logic [`RDSD_CFG_W-1:0]        scfg;
        logic [`RDSD_SYNC_W-1:0]       sval;
    } rdsd_link_cfg_t;

endpackage

/* File: src/rdsd_sync_detect.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rdsd_cfg.svh"

module rdsd_sync_detect
    import rdsd_pkg::*;
#(
    parameter int unsigned SYNC_W = `RDSD_SYNC_W
) (
    // Clock and reset.
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    // Detector carrier.
    rdsd_sync_if.det   sif
);

    localparam int unsigned CNT_W = $clog2(SYNC_W + 1);

    if (SYNC_W != `RDSD_SYNC_W) begin : g_chk
        $error("Sync window width must match the sync value width.");
    end

    logic [SYNC_W-1:0] win_q;
    logic [SYNC_W-1:0] win_d;
    logic [CNT_W-1:0]  fill_q;
    logic [CNT_W-1:0]  fill_d;
    logic              match_q;
    logic              match_d;

    function automatic logic [CNT_W-1:0] ones(input logic [SYNC_W-1:0] v);
        logic [CNT_W-1:0] s;
        s = '0;
        for (int i = 0; i < SYNC_W; i++) begin
            s = s + CNT_W'(v[i]);
        end
        return s;
    endfunction

    always_comb begin
        logic [CNT_W-1:0]  len;
        logic [SYNC_W-1:0] mask;
        logic [SYNC_W-1:0] expect_bits;
        logic [CNT_W-1:0]  errs;
        len         = CNT_W'({sif.len_sel, 3'h0}) + CNT_W'(`RDSD_BYTE_BITS);
        mask        = {SYNC_W{1'b1}} >> (CNT_W'(SYNC_W) - len);
        expect_bits = sif.sync_value >> (CNT_W'(SYNC_W) - len);
        win_d       = win_q;
        fill_d      = fill_q;
        match_d     = 1'b0;
        errs        = '0;
        if (sif.clear || !sif.enable) begin
            win_d  = '0;
            fill_d = '0;
        end else if (sif.bit_valid) begin
            win_d  = {win_q[SYNC_W-2:0], sif.bit_val};
            fill_d = (fill_q < CNT_W'(SYNC_W)) ? fill_q + CNT_W'(1) : fill_q;
            errs   = ones((win_d ^ expect_bits) & mask);
            match_d = (fill_d >= len) && (errs <= CNT_W'(sif.tol));
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            win_q   <= '0;
            fill_q  <= '0;
            match_q <= 1'b0;
        end else begin
            win_q   <= win_d;
            fill_q  <= fill_d;
            match_q <= match_d;
        end
    end

    assign sif.match = match_q;

endmodule

`default_nettype wire

/* File: src/rdsd_sync_if.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rdsd_cfg.svh"

interface rdsd_sync_if;
    import rdsd_pkg::*;
    logic                      bit_valid;
    logic                      bit_val;
    logic                      clear;
    logic                      enable;
    logic [1:0]                len_sel;
    logic [1:0]                tol;
    logic [`RDSD_SYNC_W-1:0]   sync_value;
    logic                      match;

    modport det (input bit_valid, bit_val, clear, enable, len_sel, tol, sync_value, output match);
    modport ctl (output bit_valid, bit_val, clear, enable, len_sel, tol, sync_value, input match);
endinterface

`default_nettype wire

/* File: src/rdsd_top.sv */
// Contract
// - Clear FIFO on standby-RX, RX-TX, TX-RX, any-sleep, and standby-TX when buffered.
// - Keep FIFO on RX-standby, TX-standby, and standby-TX in packet mode.
// - Sync detection runs only with its enable bit set and bit synchronizer active.
// - Shift demodulated bits, compare after each bit, raise sync event per match.
// - Earliest window bit meets sync MSB; latest meets bit 0 of last used byte.
// - Sync length is 8, 16, 24 or 32 bits from a two-bit field; its upper bit is also the sync enable bit, so detection only uses 24 or 32.
// - Up to 0 to 3 bit errors tolerated, from a two-bit field.
// - Packet transmit uses the same sync length and value bytes.
// - Data mode 00 continuous, 01 buffered, 1x packet.
// - Continuous mode passes bits on the data pin; SPI data, FIFO, handler idle.
// - Buffered mode routes every byte through FIFO and SPI, unlimited length.
// - Packet mode frames packets; only payload in FIFO, at most 64 bytes.
// - Continuous transmit drives bit clock on line one; captures data on rising edges.
// - Continuous receive, synchronizer off: raw demodulator on data pin, no clock.
// - Continuous receive, synchronizer on: clean data changes on falling clock edges.
// - Bit synchronizer forced on in buffered and packet modes.
`timescale 1ns/1ns
`default_nettype none
`include "rdsd_cfg.svh"

module rdsd_top
    import rdsd_pkg::*;
(
    // Clocks and reset.
    input  wire logic                     ref_clk_in,
    input  wire logic                     rst_n_in,
    input  wire logic                     link_clk_in,
    // Mode and sync configuration.
    input  wire logic [1:0]               chip_mode_in,
    input  wire logic                     data_mode_hi_in,
    input  wire logic                     data_mode_lo_in,
    input  wire logic [`RDSD_CFG_W-1:0]   sync_config_reg_in,
    input  wire logic [`RDSD_SYNC_W-1:0]  sync_value_in,
    // Modem side.
    input  wire logic                     demod_raw_in,
    output logic                          mod_bit_out,
    // Host pins.
    input  wire logic                     data_pin_in,
    output logic                          data_pin_out,
    output logic                          data_pin_oe_n_out,
    output logic                          irq_line_one_out,
    output logic                          irq_line_one_oe_n_out,
    // Data path control and status.
    output logic                          fifo_clear_out,
    output logic                          fifo_enable_out,
    output logic                          spi_data_enable_out,
    output logic                          packet_handler_enable_out,
    output logic                          bit_sync_active_out,
    output logic                          sync_irq_out,
    output logic [`RDSD_SYNC_W-1:0]       tx_sync_value_out,
    output logic [1:0]                    tx_sync_len_sel_out,
    output logic [6:0]                    payload_limit_out
);

    rdsd_sync_if sif ();

    // Reference domain: mode tracking and data path enables.
    rdsd_chip_mode_t     chip_cur;
    rdsd_data_mode_t     dmode;
    rdsd_chip_mode_t     prev_q;
    rdsd_chip_mode_t     prev_d;
    logic                clr_q;
    logic                clr_d;
    logic                rx_tgl_q;
    logic                rx_tgl_d;
    logic                fifo_en_q;
    logic                fifo_en_d;
    logic                pkt_en_q;
    logic                pkt_en_d;
    logic                bsync_q;
    logic                bsync_d;
    logic [`RDSD_SYNC_W-1:0] txv_q;
    logic [`RDSD_SYNC_W-1:0] txv_d;
    logic [1:0]          txl_q;
    logic [1:0]          txl_d;
    logic [6:0]          plim_q;
    logic [6:0]          plim_d;

    assign chip_cur = rdsd_chip_mode_t'(chip_mode_in);

    always_comb begin
        dmode = data_mode_hi_in ? RDSD_DM_PKT : (data_mode_lo_in ? RDSD_DM_BUF : RDSD_DM_CONT);
        prev_d   = chip_cur;
        clr_d    = 1'b0;
        rx_tgl_d = rx_tgl_q;
        if (chip_cur != prev_q) begin
            unique case (chip_cur)
                RDSD_SLEEP:   clr_d = 1'b1;
                RDSD_RX:      clr_d = (prev_q == RDSD_STANDBY) || (prev_q == RDSD_TX);
                RDSD_TX:      clr_d = (prev_q == RDSD_RX) ||
                                      ((prev_q == RDSD_STANDBY) && (dmode == RDSD_DM_BUF));
                RDSD_STANDBY: clr_d = 1'b0;
            endcase
            if (chip_cur == RDSD_RX) begin
                rx_tgl_d = ~rx_tgl_q;
            end
        end
        fifo_en_d = (dmode != RDSD_DM_CONT);
        pkt_en_d  = (dmode == RDSD_DM_PKT);
        bsync_d   = (dmode != RDSD_DM_CONT) || !sync_config_reg_in[`RDSD_BSYNC_DIS_BIT];
        txv_d     = sync_value_in;
        txl_d     = sync_config_reg_in[`RDSD_SYNC_LEN_HI:`RDSD_SYNC_LEN_LO];
        plim_d    = (dmode == RDSD_DM_PKT) ? `RDSD_PAYLOAD_MAX : `RDSD_PAYLOAD_NONE;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            prev_q    <= RDSD_SLEEP;
            clr_q     <= 1'b0;
            rx_tgl_q  <= 1'b0;
            fifo_en_q <= 1'b0;
            pkt_en_q  <= 1'b0;
            bsync_q   <= 1'b0;
            txv_q     <= `RDSD_SYNC_RST;
            txl_q     <= 2'h0;
            plim_q    <= `RDSD_PAYLOAD_NONE;
        end else begin
            prev_q    <= prev_d;
            clr_q     <= clr_d;
            rx_tgl_q  <= rx_tgl_d;
            fifo_en_q <= fifo_en_d;
            pkt_en_q  <= pkt_en_d;
            bsync_q   <= bsync_d;
            txv_q     <= txv_d;
            txl_q     <= txl_d;
            plim_q    <= plim_d;
        end
    end

    // Reference domain: sync event toggle back from the link domain.
    logic match_tgl_q;
    logic m_meta_q;
    logic m_sync_q;
    logic m_last_q;
    logic m_sync_d;
    logic m_last_d;
    logic sirq_q;
    logic sirq_d;

    always_comb begin
        m_sync_d = m_meta_q;
        m_last_d = m_sync_q;
        sirq_d   = m_sync_q ^ m_last_q;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            m_meta_q <= 1'b0;
            m_sync_q <= 1'b0;
            m_last_q <= 1'b0;
            sirq_q   <= 1'b0;
        end else begin
            m_meta_q <= match_tgl_q;
            m_sync_q <= m_sync_d;
            m_last_q <= m_last_d;
            sirq_q   <= sirq_d;
        end
    end

    // Link domain: reset, configuration and pin synchronisers.
    rdsd_link_cfg_t cfg_raw;
    rdsd_link_cfg_t cfg_meta_q;
    rdsd_link_cfg_t cfg_sync_q;
    rdsd_link_cfg_t cfg_prev_q;
    rdsd_link_cfg_t cfg_d;
    rdsd_link_cfg_t cfg_q;
    logic           lrst_meta_q;
    logic           lrst_n_q;
    logic           rx_meta_q;
    logic           rx_sync_q;
    logic           rx_last_q;
    logic           din_meta_q;
    logic           din_q;
    logic           dem_meta_q;
    logic           dem_q;

    assign cfg_raw = '{chip: chip_cur, dm_hi: data_mode_hi_in, dm_lo: data_mode_lo_in,
                       scfg: sync_config_reg_in, sval: sync_value_in};
    assign cfg_d   = (cfg_sync_q == cfg_prev_q) ? cfg_prev_q : cfg_q;

    // The configuration word is taken only once two synchronised samples agree.
    always_ff @(posedge link_clk_in) begin
        lrst_meta_q <= rst_n_in;
        lrst_n_q    <= lrst_meta_q;
        cfg_meta_q  <= cfg_raw;
        cfg_sync_q  <= cfg_meta_q;
        cfg_prev_q  <= cfg_sync_q;
        cfg_q       <= cfg_d;
        rx_meta_q   <= rx_tgl_q;
        rx_sync_q   <= rx_meta_q;
        rx_last_q   <= rx_sync_q;
        din_meta_q  <= data_pin_in;
        din_q       <= din_meta_q;
        dem_meta_q  <= demod_raw_in;
        dem_q       <= dem_meta_q;
    end

    // Link domain: bit clock, pin drive and detector feed.
    rdsd_link_state_t lst;
    logic             cont;
    logic             lbsync;
    logic             ph_q;
    logic             ph_d;
    logic             mod_q;
    logic             mod_d;
    logic             dout_q;
    logic             dout_d;
    logic             doe_n_q;
    logic             doe_n_d;
    logic             ck_q;
    logic             ck_d;
    logic             ckoe_n_q;
    logic             ckoe_n_d;
    logic             bv_q;
    logic             bv_d;
    logic             bval_q;
    logic             bval_d;
    logic             sclr_q;
    logic             sclr_d;
    logic             mtgl_d;

    always_comb begin
        cont   = !cfg_q.dm_hi && !cfg_q.dm_lo;
        lbsync = !cont || !cfg_q.scfg[`RDSD_BSYNC_DIS_BIT];
        if (cont && (cfg_q.chip == RDSD_TX)) begin
            lst = RDSD_LK_CONT_TX;
        end else if ((cfg_q.chip == RDSD_RX) && !lbsync) begin
            lst = RDSD_LK_RX_RAW;
        end else if (cfg_q.chip == RDSD_RX) begin
            lst = RDSD_LK_RX_SYNC;
        end else begin
            lst = RDSD_LK_IDLE;
        end
        ph_d     = 1'b0;
        mod_d    = mod_q;
        dout_d   = dout_q;
        doe_n_d  = 1'b1;
        ckoe_n_d = 1'b1;
        bv_d     = 1'b0;
        bval_d   = bval_q;
        sclr_d   = rx_sync_q ^ rx_last_q;
        mtgl_d   = match_tgl_q ^ sif.match;
        unique case (lst)
            RDSD_LK_IDLE: begin
                mod_d  = 1'b0;
                dout_d = 1'b0;
            end
            RDSD_LK_CONT_TX: begin
                ph_d     = ~ph_q;
                ckoe_n_d = 1'b0;
                if (!ph_q) begin
                    mod_d = din_q;
                end
            end
            RDSD_LK_RX_RAW: begin
                dout_d  = dem_q;
                doe_n_d = 1'b0;
            end
            RDSD_LK_RX_SYNC: begin
                ph_d     = ~ph_q;
                ckoe_n_d = !cont;
                doe_n_d  = !cont;
                if (ph_q) begin
                    dout_d = dem_q;
                    bv_d   = 1'b1;
                    bval_d = dem_q;
                end
            end
        endcase
        ck_d = ph_d && !ckoe_n_d;
    end

    always_ff @(posedge link_clk_in) begin
        if (!lrst_n_q) begin
            ph_q        <= 1'b0;
            mod_q       <= 1'b0;
            dout_q      <= 1'b0;
            doe_n_q     <= 1'b1;
            ck_q        <= 1'b0;
            ckoe_n_q    <= 1'b1;
            bv_q        <= 1'b0;
            bval_q      <= 1'b0;
            sclr_q      <= 1'b0;
            match_tgl_q <= 1'b0;
        end else begin
            ph_q        <= ph_d;
            mod_q       <= mod_d;
            dout_q      <= dout_d;
            doe_n_q     <= doe_n_d;
            ck_q        <= ck_d;
            ckoe_n_q    <= ckoe_n_d;
            bv_q        <= bv_d;
            bval_q      <= bval_d;
            sclr_q      <= sclr_d;
            match_tgl_q <= mtgl_d;
        end
    end

    assign sif.bit_valid  = bv_q;
    assign sif.bit_val    = bval_q;
    assign sif.clear      = sclr_q;
    assign sif.enable     = cfg_q.scfg[`RDSD_SYNC_EN_BIT] && lbsync && (cfg_q.chip == RDSD_RX);
    assign sif.len_sel    = cfg_q.scfg[`RDSD_SYNC_LEN_HI:`RDSD_SYNC_LEN_LO];
    assign sif.tol        = cfg_q.scfg[`RDSD_SYNC_TOL_HI:`RDSD_SYNC_TOL_LO];
    assign sif.sync_value = cfg_q.sval;

    rdsd_sync_detect #(
        .SYNC_W (`RDSD_SYNC_W)
    ) rdsd_sync_detect_inst (
        .clk_in   (link_clk_in),
        .rst_n_in (lrst_n_q),
        .sif      (sif)
    );

    assign fifo_clear_out            = clr_q;
    assign fifo_enable_out           = fifo_en_q;
    assign spi_data_enable_out       = fifo_en_q;
    assign packet_handler_enable_out = pkt_en_q;
    assign bit_sync_active_out       = bsync_q;
    assign sync_irq_out              = sirq_q;
    assign tx_sync_value_out         = txv_q;
    assign tx_sync_len_sel_out       = txl_q;
    assign payload_limit_out         = plim_q;
    assign mod_bit_out               = mod_q;
    assign data_pin_out              = dout_q;
    assign data_pin_oe_n_out         = doe_n_q;
    assign irq_line_one_out          = ck_q;
    assign irq_line_one_oe_n_out     = ckoe_n_q;

endmodule

`default_nettype wire
